// file: pcf_pkg.sv
// constants and register map of the pulse counter with compare and frequency measurement
// assumes a single 50 MHz clock and a plain strobe register port
//
// Overview of operation
// - mode low region: compare status high while count is at or below compare value
// - mode 1 sets status above compare value, mode 2 selects region at or below
// - routed output follows compare status, program writes to that output are ignored
// - output channel fault never stops counting or compare updates
// - output routing stays in force when the counted input is deactivated
// - slot disabled: count, compare status and routed output hold, output stays locked
// - enabled compare interrupt fires on each zero to one of compare status
// - rising edge of load strobe copies load value into the count
// - load acts at once, whether or not the gate is open
// - internal gate is software gate AND hardware gate input
// - frequency measurement runs beside normal input use, input level stays readable
// - frequency reported in hertz as single precision float
// - window length adapts to input frequency, value refreshed every window
// - frequency is rising edges in window divided by window seconds
// - results valid only from 0.1 Hz to 1 kHz, otherwise undefined
package pcf_pkg;
    localparam int          ADDR_W        = 6;
    localparam int          DATA_W        = 32;
    localparam int          EDGE_W        = 20;
    // register byte offsets
    localparam logic [5:0]  OFS_CTRL      = 6'h00;
    localparam logic [5:0]  OFS_LOAD      = 6'h04;
    localparam logic [5:0]  OFS_CMP       = 6'h08;
    localparam logic [5:0]  OFS_COUNT     = 6'h0c;
    localparam logic [5:0]  OFS_STAT      = 6'h10;
    localparam logic [5:0]  OFS_IRQ_STAT  = 6'h14;
    localparam logic [5:0]  OFS_IRQ_MASK  = 6'h18;
    localparam logic [5:0]  OFS_DOUT      = 6'h1c;
    localparam logic [5:0]  OFS_FREQ      = 6'h20;
    // control fields
    localparam int          CTL_SOFTWARE_COUNT_GATE   = 0;
    localparam int          CTL_LOAD      = 1;
    localparam int          CTL_MODE_LO   = 2;
    localparam int          CTL_IRQ_EN    = 4;
    localparam int          CTL_ROUTE     = 5;
    localparam int          CTL_SLOT_EN   = 6;
    localparam int          CTL_CH_EN     = 7;
    localparam int          CTL_W         = 8;
    localparam logic [7:0]  CTL_RESET     = 8'h00;
    // compare mode settings
    localparam logic [1:0]  MODE_HIGH     = 2'h1;
    localparam logic [1:0]  MODE_LOW      = 2'h2;
    // status and interrupt bits
    localparam int          IRQ_CMP       = 0;
    localparam int          IRQ_FREQ      = 1;
    localparam int          IRQ_W         = 2;
    // float construction
    localparam logic [7:0]  FLT_BIAS      = 8'h7f;
    localparam logic [31:0] FLT_ZERO      = 32'h0000_0000;
    // window adaptation: base 0.125 s, then x8 (1 s) and x128 (16 s)
    localparam longint      WIN_BASE_NS   = 125_000_000;
    localparam longint      CLK_PERIOD_NS = 20;
    localparam longint      WIN_BASE_CYC  = (WIN_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [EDGE_W-1:0] EDGE_SHRINK = 20'h0_0040;
    localparam logic [EDGE_W-1:0] EDGE_GROW   = 20'h0_0004;
    typedef enum logic [1:0] {
        PCF_WIN_SHORT = 2'b00,
        PCF_WIN_MID   = 2'b01,
        PCF_WIN_LONG  = 2'b10
    } pcf_win_e;
    // window length as power-of-two multiple of base, and seconds exponent
    localparam int          WIN_MID_SH    = 3;
    localparam int          WIN_LONG_SH   = 7;
    localparam int          EXP_SHORT     = 3;
    localparam int          EXP_LONG      = -4;
endpackage

// file: pcf_top.sv
// pulse counter channel with compare output, load, gate and frequency measurement
// assumes synchronous inputs, one clock, registers on a strobe port with one cycle read latency
`timescale 1ns/100ps
module pcf_top
    import pcf_pkg::*;
#(
    parameter longint WIN_BASE_CYCLES = WIN_BASE_CYC
) (
    input  wire logic              clock_in,          // 50 MHz clock
    input  wire logic              reset_in,          // synchronous reset, active high
    input  wire logic              ce_in,             // clock enable, freezes all state
    input  wire logic [ADDR_W-1:0] addr_in,           // register byte address
    input  wire logic [DATA_W-1:0] wdata_in,          // register write data
    input  wire logic              wr_in,             // write strobe
    input  wire logic              rd_in,             // read strobe
    output logic      [DATA_W-1:0] rdata_out,         // read data, cycle after strobe
    input  wire logic              counted_input_in,  // counted digital input
    input  wire logic              hardware_count_gate_in, // hardware gate, high is open
    input  wire logic              output_fault_in,   // fault seen on output channel
    output logic                   dq_out,            // free digital output level
    output logic                   irq_out,           // level interrupt
    output logic                   cmp_pulse_out      // one cycle compare rise request
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CTL_W-1:0]  ctrl;
        logic              load_prev;
        logic [DATA_W-1:0] load_val;
        logic [DATA_W-1:0] cmp_val;
        logic [DATA_W-1:0] count;
        logic              compare_status;
        logic              cmp_prev;
        logic              cmp_pulse;
        logic              dout_prog;
        logic              dq;
        logic              in_prev;
        logic              in_level;
        logic              fault;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic              irq;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] win_cnt;
        logic [EDGE_W-1:0] edges;
        pcf_win_e          win;
        logic [DATA_W-1:0] freq;
    } pcf_state_s;

    pcf_state_s st_ff;
    pcf_state_s nxt_st;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // edges to float hertz, exponent shifted by window seconds exponent
    function automatic logic [31:0] pcf_to_float(input logic [EDGE_W-1:0] n, input int adj);
        int          msb;
        logic [22:0] man;
        logic [EDGE_W-1:0] sh;
        msb = 0;
        man = '0;
        sh  = '0;
        for (int i = 0; i < EDGE_W; i++) begin
            if (n[i]) begin
                msb = i;
            end
        end
        sh  = n << (EDGE_W - msb);
        man = {sh, 3'h0};
        if (n == '0) begin
            return FLT_ZERO;
        end
        return {1'b0, FLT_BIAS + 8'(msb + adj), man};
    endfunction

    function automatic logic [DATA_W-1:0] pcf_win_len(input pcf_win_e w);
        unique case (w)
            PCF_WIN_SHORT: return DATA_W'(WIN_BASE_CYCLES);
            PCF_WIN_MID:   return DATA_W'(WIN_BASE_CYCLES << WIN_MID_SH);
            PCF_WIN_LONG:  return DATA_W'(WIN_BASE_CYCLES << WIN_LONG_SH);
            default:       return DATA_W'(WIN_BASE_CYCLES);
        endcase
    endfunction

    function automatic int pcf_win_exp(input pcf_win_e w);
        unique case (w)
            PCF_WIN_SHORT: return EXP_SHORT;
            PCF_WIN_MID:   return 0;
            PCF_WIN_LONG:  return EXP_LONG;
            default:       return 0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic              slot_en;
    logic              gate_open;
    logic              in_rise;
    logic              load_rise;
    logic              cmp_next;
    logic              win_end;
    logic [1:0]        mode;
    logic [IRQ_W-1:0]  irq_set;

    always_comb begin
        nxt_st    = st_ff;
        slot_en   = st_ff.ctrl[CTL_SLOT_EN];
        mode      = st_ff.ctrl[CTL_MODE_LO +: 2];
        // faults are only recorded, they feed nothing in the count path
        nxt_st.fault    = output_fault_in;
        nxt_st.in_prev  = counted_input_in;
        nxt_st.in_level = counted_input_in;
        in_rise   = counted_input_in & ~st_ff.in_prev;
        gate_open = st_ff.ctrl[CTL_SOFTWARE_COUNT_GATE] & hardware_count_gate_in;
        nxt_st.load_prev = st_ff.ctrl[CTL_LOAD];
        load_rise = st_ff.ctrl[CTL_LOAD] & ~st_ff.load_prev;
        irq_set   = '0;

        // counting, load wins over a pulse in the same cycle
        if (slot_en) begin
            if (load_rise) begin
                nxt_st.count = st_ff.load_val;
            end else if (gate_open && st_ff.ctrl[CTL_CH_EN] && in_rise) begin
                nxt_st.count = st_ff.count + 32'h0000_0001;
            end
        end

        // compare evaluation on the registered count
        unique case (mode)
            MODE_HIGH: cmp_next = st_ff.count > st_ff.cmp_val;
            MODE_LOW:  cmp_next = st_ff.count <= st_ff.cmp_val;
            default:   cmp_next = 1'b0;
        endcase
        if (slot_en) begin
            nxt_st.compare_status = cmp_next;
        end
        nxt_st.cmp_prev  = st_ff.compare_status;
        // rise against previous clock value, single cycle
        nxt_st.cmp_pulse = st_ff.compare_status & ~st_ff.cmp_prev
                           & st_ff.ctrl[CTL_IRQ_EN];
        irq_set[IRQ_CMP] = nxt_st.cmp_pulse;

        // output: routing independent of channel enable, frozen with slot
        if (slot_en) begin
            if (st_ff.ctrl[CTL_ROUTE]) begin
                nxt_st.dq = st_ff.compare_status;
            end else begin
                nxt_st.dq = st_ff.dout_prog;
            end
        end

        // frequency measurement, independent of gate and counter mode
        win_end = st_ff.win_cnt >= pcf_win_len(st_ff.win) - 32'h0000_0001;
        if (win_end) begin
            nxt_st.win_cnt = '0;
            nxt_st.edges   = EDGE_W'(in_rise);
            nxt_st.freq    = pcf_to_float(st_ff.edges, pcf_win_exp(st_ff.win));
            irq_set[IRQ_FREQ] = 1'b1;
            // adapt window for next measurement
            if (st_ff.edges >= EDGE_SHRINK && st_ff.win != PCF_WIN_SHORT) begin
                nxt_st.win = (st_ff.win == PCF_WIN_LONG) ? PCF_WIN_MID : PCF_WIN_SHORT;
            end else if (st_ff.edges < EDGE_GROW && st_ff.win != PCF_WIN_LONG) begin
                nxt_st.win = (st_ff.win == PCF_WIN_SHORT) ? PCF_WIN_MID : PCF_WIN_LONG;
            end
        end else begin
            nxt_st.win_cnt = st_ff.win_cnt + 32'h0000_0001;
            // saturate: beyond the valid range the result is undefined anyway
            if (in_rise && st_ff.edges != '1) begin
                nxt_st.edges = st_ff.edges + 20'h0_0001;
            end
        end

        // register writes
        if (wr_in) begin
            unique case (addr_in)
                OFS_CTRL:     nxt_st.ctrl     = wdata_in[CTL_W-1:0];
                OFS_LOAD:     nxt_st.load_val = wdata_in;
                OFS_CMP:      nxt_st.cmp_val  = wdata_in;
                OFS_IRQ_MASK: nxt_st.irq_mask = wdata_in[IRQ_W-1:0];
                // stored always, reaches the pin only when not routed
                OFS_DOUT:     nxt_st.dout_prog = wdata_in[0];
                default:      ;
            endcase
        end

        // reads, status cleared by reading, new events win
        nxt_st.rdata = '0;
        nxt_st.irq_stat = st_ff.irq_stat | irq_set;
        if (rd_in) begin
            unique case (addr_in)
                OFS_CTRL:     nxt_st.rdata = DATA_W'(st_ff.ctrl);
                OFS_LOAD:     nxt_st.rdata = st_ff.load_val;
                OFS_CMP:      nxt_st.rdata = st_ff.cmp_val;
                OFS_COUNT:    nxt_st.rdata = st_ff.count;
                OFS_STAT:     nxt_st.rdata = DATA_W'({st_ff.in_level, st_ff.fault, st_ff.dq,
                                                      gate_open, st_ff.compare_status});
                OFS_IRQ_STAT: begin
                    nxt_st.rdata    = DATA_W'(st_ff.irq_stat);
                    nxt_st.irq_stat = irq_set;
                end
                OFS_IRQ_MASK: nxt_st.rdata = DATA_W'(st_ff.irq_mask);
                OFS_DOUT:     nxt_st.rdata = DATA_W'(st_ff.dout_prog);
                OFS_FREQ:     nxt_st.rdata = st_ff.freq;
                default:      nxt_st.rdata = '0;
            endcase
        end
        nxt_st.irq = |(nxt_st.irq_stat & st_ff.irq_mask);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st_ff      <= '0;
            st_ff.ctrl <= CTL_RESET;
            st_ff.win  <= PCF_WIN_SHORT;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_out     = st_ff.rdata;
    assign dq_out        = st_ff.dq;
    assign irq_out       = st_ff.irq;
    assign cmp_pulse_out = st_ff.cmp_pulse;
endmodule

// file: pcf_monitor.sv
// checker for the pulse counter channel, sees only the top ports
// assumes one clock domain, bound into pcf_top
`timescale 1ns/100ps
module pcf_monitor
    import pcf_pkg::*;
#(
    parameter longint WIN_BASE_CYCLES = WIN_BASE_CYC
) (
    input  wire logic              clock_in,               // clock
    input  wire logic              reset_in,               // reset
    input  wire logic              ce_in,                  // enable
    input  wire logic [ADDR_W-1:0] addr_in,                // address
    input  wire logic [DATA_W-1:0] wdata_in,               // write data
    input  wire logic              wr_in,                  // write
    input  wire logic              rd_in,                  // read
    input  wire logic [DATA_W-1:0] rdata_out,              // read data
    input  wire logic              counted_input_in,       // input
    input  wire logic              hardware_count_gate_in, // gate
    input  wire logic              output_fault_in,        // fault
    input  wire logic              dq_out,                 // output
    input  wire logic              irq_out,                // interrupt
    input  wire logic              cmp_pulse_out           // rise pulse
);
    logic [CTL_W-1:0]  ctrl_ff;
    logic [DATA_W-1:0] load_ff;
    logic [IRQ_W-1:0]  mask_ff;
    logic [1:0]        on_ff;
    logic [1:0]        off_ff;
    logic              wr_hit;
    assign wr_hit = ce_in && wr_in;
    // --------------------------------
    // shadow of written registers, and cycle counters for routed output with slot on and off
    // --------------------------------
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ctrl_ff <= CTL_RESET;
            load_ff <= '0;
            mask_ff <= '0;
            on_ff   <= 2'h0;
            off_ff  <= 2'h0;
        end else begin
            ctrl_ff <= (wr_hit && addr_in == OFS_CTRL) ? wdata_in[CTL_W-1:0] : ctrl_ff;
            load_ff <= (wr_hit && addr_in == OFS_LOAD) ? wdata_in : load_ff;
            mask_ff <= (wr_hit && addr_in == OFS_IRQ_MASK) ? wdata_in[IRQ_W-1:0] : mask_ff;
            on_ff   <= !(ctrl_ff[CTL_ROUTE] && ctrl_ff[CTL_SLOT_EN]) ? 2'h0 :
                       (on_ff == 2'h3) ? on_ff : on_ff + 2'h1;
            off_ff  <= !(ctrl_ff[CTL_ROUTE] && !ctrl_ff[CTL_SLOT_EN]) ? 2'h0 :
                       (off_ff == 2'h3) ? off_ff : off_ff + 2'h1;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    sequence s_load;
        ce_in && wr_in && addr_in == OFS_CTRL && wdata_in[CTL_LOAD] && !ctrl_ff[CTL_LOAD]
            && wdata_in[CTL_SLOT_EN] && !wdata_in[CTL_SOFTWARE_COUNT_GATE];
    endsequence
    sequence s_count_rd;
        ce_in ##1 (ce_in && rd_in && addr_in == OFS_COUNT);
    endsequence
    AST_LOAD_COUNT: assert property (s_load ##1 s_count_rd |=> rdata_out == load_ff)
        else $error("count differs from load value");
    AST_PULSE_ONE: assert property (cmp_pulse_out |=> !cmp_pulse_out)
        else $error("compare pulse longer than one cycle");
    AST_PULSE_EN: assert property (cmp_pulse_out |-> $past(ctrl_ff[CTL_IRQ_EN]))
        else $error("compare pulse while interrupt disabled");
    AST_ROUTE_DQ: assert property (cmp_pulse_out && on_ff == 2'h3 |-> dq_out)
        else $error("routed output not following compare status");
    AST_SLOT_HOLD: assert property (off_ff == 2'h3 |-> $stable(dq_out))
        else $error("output moved while slot disabled");
    AST_IRQ_RAISE: assert property (cmp_pulse_out && mask_ff[IRQ_CMP] |-> ##[0:2] irq_out)
        else $error("unmasked compare event gave no interrupt");
    AST_IRQ_MASKED: assert property (mask_ff == '0 && $past(mask_ff) == '0 |-> !irq_out)
        else $error("interrupt high with all sources masked");
    AST_RD_IDLE: assert property (ce_in && !rd_in |=> rdata_out == '0)
        else $error("read data outside read cycle");
    AST_RD_UNMAPPED: assert property (ce_in && rd_in && addr_in == 6'h3c |=> rdata_out == '0)
        else $error("unmapped read not zero");
endmodule
bind pcf_top pcf_monitor #(.WIN_BASE_CYCLES(WIN_BASE_CYCLES)) u_mon (
    .clock_in(clock_in), .reset_in(reset_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .counted_input_in(counted_input_in), .hardware_count_gate_in(hardware_count_gate_in),
    .output_fault_in(output_fault_in), .dq_out(dq_out), .irq_out(irq_out),
    .cmp_pulse_out(cmp_pulse_out));

// file: pcf_pulse_src.sv
// pulse source standing in for the field signal on the counted input
// assumes the channel clock, line rests low while idle
`timescale 1ns/100ps
module pcf_pulse_src (
    input  wire logic clock_in,  // clock
    input  wire logic run_in,    // toggle while high
    output logic      level_out  // counted input level
);
    logic level_ff = 1'b0;
    always_ff @(posedge clock_in) begin
        level_ff <= run_in ? !level_ff : 1'b0;
    end
    assign level_out = level_ff;
endmodule

// file: pulse_counter_compare_freq_tb_top.sv
// self-checking bench for the pulse counter channel
// assumes pcf_top, pcf_pulse_src and the bound checker compiled first
`timescale 1ns/100ps
module pulse_counter_compare_freq_tb_top;
    import pcf_pkg::*;
    localparam logic [DATA_W-1:0] CFG = 32'h0000_00f0;
    logic              clock_in = 1'b0;
    logic              reset_in = 1'b1;
    logic [ADDR_W-1:0] addr_in  = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic              wr_in    = 1'b0;
    logic              rd_in    = 1'b0;
    logic              ce_in    = 1'b1;
    logic              run_in   = 1'b0;
    logic              gate_in  = 1'b0;
    logic              fault_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    logic              counted_w, dq_out, irq_out, pulse_out;
    int                errors = 0;
    int                check_count = 0;
    always #10 clock_in = ~clock_in;
    pcf_pulse_src u_src (.clock_in(clock_in), .run_in(run_in), .level_out(counted_w));
    pcf_top #(.WIN_BASE_CYCLES(16)) uut (
        .clock_in(clock_in), .reset_in(reset_in), .ce_in(ce_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .counted_input_in(counted_w), .hardware_count_gate_in(gate_in),
        .output_fault_in(fault_in), .dq_out(dq_out), .irq_out(irq_out),
        .cmp_pulse_out(pulse_out));
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
    endtask
    task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                       input logic [DATA_W-1:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        #1 cmp_word(rdata_out & m, exp);
    endtask
    task automatic pulses(input int k);
        @(posedge clock_in);
        run_in <= 1'b1;
        repeat (2 * k) @(posedge clock_in);
        run_in <= 1'b0;
        repeat (4) @(posedge clock_in);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        chk(OFS_CTRL, '1, 32'h0000_0000);
        chk(6'h3c, '1, 32'h0000_0000);
        $display("reset test done");
        wr(OFS_LOAD, 32'h0000_0005);
        wr(OFS_CMP, 32'h0000_0006);
        wr(OFS_CTRL, CFG | 32'h0000_0008);
        wr(OFS_CTRL, CFG | 32'h0000_000a);
        chk(OFS_COUNT, '1, 32'h0000_0005);
        chk(OFS_STAT, 32'h0000_0003, 32'h0000_0001);
        cmp_bit(dq_out, 1'b1);
        pulses(2);
        chk(OFS_COUNT, '1, 32'h0000_0005);
        wr(OFS_CTRL, CFG | 32'h0000_000b);
        pulses(2);
        chk(OFS_COUNT, '1, 32'h0000_0005);
        gate_in  <= 1'b1;
        fault_in <= 1'b1;
        pulses(1);
        chk(OFS_STAT, 32'h0000_0003, 32'h0000_0003);
        pulses(1);
        chk(OFS_COUNT, '1, 32'h0000_0007);
        chk(OFS_STAT, 32'h0000_0001, 32'h0000_0000);
        ce_in <= 1'b0;
        pulses(2);
        ce_in <= 1'b1;
        chk(OFS_COUNT, '1, 32'h0000_0007);
        wr(OFS_DOUT, 32'h0000_0001);
        repeat (3) @(posedge clock_in);
        cmp_bit(dq_out, 1'b0);
        $display("count test done");
        chk(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        wr(OFS_CTRL, CFG | 32'h0000_0007);
        for (int i = 0; i < 8 && irq_out !== 1'b1; i++) @(posedge clock_in);
        cmp_bit(irq_out, 1'b1);
        chk(OFS_STAT, 32'h0000_0001, 32'h0000_0001);
        chk(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
        repeat (2) @(posedge clock_in);
        cmp_bit(irq_out, 1'b0);
        $display("interrupt test done");
        wr(OFS_CTRL, 32'h0000_00b7);
        pulses(2);
        chk(OFS_COUNT, '1, 32'h0000_0007);
        wr(OFS_DOUT, 32'h0000_0000);
        repeat (3) @(posedge clock_in);
        cmp_bit(dq_out, 1'b1);
        wr(OFS_CTRL, 32'h0000_0077);
        pulses(2);
        chk(OFS_COUNT, '1, 32'h0000_0007);
        wr(OFS_CMP, 32'h0000_0008);
        repeat (4) @(posedge clock_in);
        cmp_bit(dq_out, 1'b0);
        wr(OFS_CTRL, 32'h0000_0067);
        wr(OFS_CMP, 32'h0000_0006);
        repeat (4) @(posedge clock_in);
        cmp_bit(dq_out, 1'b1);
        cmp_bit(irq_out, 1'b0);
        chk(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0000);
        $display("hold test done");
        run_in <= 1'b1;
        repeat (3000) @(posedge clock_in);
        chk(OFS_FREQ, '1, 32'h4280_0000);
        chk(OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
        repeat (20) @(posedge clock_in);
        chk(OFS_FREQ, '1, 32'h4280_0000);
        $display("frequency test done");
        give_verdict();
    end
endmodule
